// ### hw/alu_instruction_execute.sv
// Execute unit for add and AND instructions with port, timer and counter side effects
//
// Contract
// RULE1 - Writing the counter low byte clears bit eight
// RULE2 - Port operands are read from pin levels
// RULE3 - Direction load copies accumulator to port latches
// RULE4 - Direction one floats pin, zero drives it
// RULE5 - Timer count write clears assigned prescaler
// RULE6 - Destination bit picks accumulator or file
// RULE7 - AND with file sets zero, one cycle
// RULE8 - AND with literal into accumulator, zero flag
// RULE9 - Add with file sets carry, digit, zero
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module alu_instruction_execute (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic [11:0]       instr,
	input  wire logic              instrValid,
	input  wire logic [2:0][7:0]   pinIn,
	output logic      [2:0][7:0]   pinOut,
	output logic      [2:0][7:0]   pinOe,
	output logic                   prescalerClear,
	output logic      [8:0]        pcValue,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr
);

	// Whole state of the unit in one record
	typedef struct packed {
		logic [31:0][7:0] fileReg;      // File registers, ports hold output latches
		logic [7:0]       accum;        // Accumulator
		logic [8:0]       pc;           // Program counter
		logic [2:0][7:0]  dirLatch;     // Direction latches A, B, C
		logic [2:0][7:0]  outEnable;    // Registered driver enables
		logic [2:0][7:0]  pinSync1;     // First synchroniser stage
		logic [2:0][7:0]  pinSync2;     // Second stage
		logic [2:0][7:0]  pinSync3;     // Third stage
		logic [2:0][7:0]  pinLevel;     // Filtered pin levels
		logic             prescAssign;  // Prescaler belongs to the timer
		logic             prescClr;     // One-cycle prescaler clear
		logic             apbReady;     // Access phase answer
		logic [31:0]      apbData;      // Read data
		logic             apbErr;       // Unmapped address
	} state_t;

	state_t state_r;   // Registered state
	state_t state_nxt; // Next state

	alu_if aluBus ();  // Bundle to the arithmetic core

	// Arithmetic core
	alu_core aluUnit (
		.alu (aluBus.core)
	);

	// Decoded instruction fields
	logic [4:0] fileAddr;   // File operand
	logic       destFile;   // Destination bit
	logic       isAddFile;  // add_accum_file
	logic       isAndFile;  // and_accum_file
	logic       isAndLit;   // and_literal_accum
	logic       isDirLoad;  // port_direction_load with a port operand
	logic [1:0] portIdx;    // Port index for 5..7

	// Ports sit at three consecutive file addresses
	function automatic logic isPortAddr(input logic [4:0] addr);
		return (addr >= alu_exec_pkg::FILE_PORT_A) && (addr <= alu_exec_pkg::FILE_PORT_C);
	endfunction

	// Port index 0..2 of a port file address
	function automatic logic [1:0] portOf(input logic [4:0] addr);
		return 2'(addr - alu_exec_pkg::FILE_PORT_A);
	endfunction

	// Port addresses return pins, the counter low byte returns the live counter, every other address returns storage
	function automatic logic [7:0] readFile(input state_t s, input logic [4:0] addr);
		// Pin levels, so a read-modify-write never echoes a latch the pin disagrees with
		if (isPortAddr(addr)) begin
			return s.pinLevel[portOf(addr)]; // RULE2
		end
		// Counter low byte read live; the stored copy is never refreshed
		if (addr == alu_exec_pkg::FILE_PCL) begin
			return s.pc[7:0];
		end
		return s.fileReg[addr];
	endfunction

	// Field decode; unknown opcodes simply advance the counter
	always_comb begin
		fileAddr  = instr[4:0];
		destFile  = instr[5];
		portIdx   = portOf(instr[4:0]);
		isAddFile = (instr[11:6] == alu_exec_pkg::OPC_ADD_FILE);
		isAndFile = (instr[11:6] == alu_exec_pkg::OPC_AND_FILE);
		isAndLit  = (instr[11:8] == alu_exec_pkg::OPC_AND_LIT);
		// Only port operands load a latch; other operands are ignored
		isDirLoad = (instr[11:3] == alu_exec_pkg::OPC_DIR_LOAD)
			&& isPortAddr(instr[4:0]); // RULE3
		// Operands always presented so the core output is defined
		// Kept out of the next-state process, which reads the core's result
		aluBus.opA = state_r.accum;
		aluBus.opB = isAndLit ? instr[7:0] : readFile(state_r, fileAddr); // RULE2
		aluBus.op  = isAddFile ? alu_exec_pkg::ALU_ADD : alu_exec_pkg::ALU_AND;
	end

	// Next-state logic: pins, instruction execution and bus slave
	always_comb begin
		state_nxt = state_r;
		if (ce) begin
			// Three-stage pin capture; a level counts once stages two and three agree
			// Costs four edges of latency on a pin read, bought for glitch immunity
			state_nxt.pinSync1 = pinIn;
			state_nxt.pinSync2 = state_r.pinSync1;
			state_nxt.pinSync3 = state_r.pinSync2;
			state_nxt.pinLevel = (~(state_r.pinSync2 ^ state_r.pinSync3) & state_r.pinSync3)
				| ((state_r.pinSync2 ^ state_r.pinSync3) & state_r.pinLevel);
			// Pulse lasts one enabled cycle; the prescaler itself lives outside
			state_nxt.prescClr = 1'b0;
			// One instruction per enabled valid cycle
			if (instrValid) begin
				state_nxt.pc = state_r.pc + 9'h001;
				if (isAddFile || isAndFile) begin
					// Result goes to the file or to the accumulator
					if (destFile) begin
						state_nxt.fileReg[fileAddr] = aluBus.result; // RULE6
						// Counter written as data: ninth bit cleared
						if (fileAddr == alu_exec_pkg::FILE_PCL) begin
							state_nxt.pc = {1'b0, aluBus.result}; // RULE1
						end
						// Timer rewritten: drop the prescaler count
						if (fileAddr == alu_exec_pkg::FILE_TIMER && state_r.prescAssign) begin
							state_nxt.prescClr = 1'b1; // RULE5
						end
					end else begin
						state_nxt.accum = aluBus.result; // RULE6
					end
					// Flag update wins over a direct write of the flag byte
					state_nxt.fileReg[alu_exec_pkg::FILE_STATUS][alu_exec_pkg::FLAG_Z] =
						aluBus.zeroOut; // RULE7
					if (isAddFile) begin
						state_nxt.fileReg[alu_exec_pkg::FILE_STATUS][alu_exec_pkg::FLAG_C] =
							aluBus.carryOut; // RULE9
						state_nxt.fileReg[alu_exec_pkg::FILE_STATUS][alu_exec_pkg::FLAG_DIGIT] =
							aluBus.digitOut; // RULE9
					end
				end else if (isAndLit) begin
					// Literal AND always lands in the accumulator
					state_nxt.accum = aluBus.result; // RULE8
					state_nxt.fileReg[alu_exec_pkg::FILE_STATUS][alu_exec_pkg::FLAG_Z] =
						aluBus.zeroOut; // RULE8
				end else if (isDirLoad) begin
					// Accumulator into the selected direction latch
					state_nxt.dirLatch[portIdx]  = state_r.accum; // RULE3
					state_nxt.outEnable[portIdx] = ~state_r.accum; // RULE4
				end
			end
			// Bus slave: answer decided in setup, driven during the first access cycle
			if (state_r.apbReady) begin
				state_nxt.apbReady = 1'b0;
				// Write lands on the completing edge only
				if (psel && penable && pwrite && paddr == alu_exec_pkg::REG_CTRL) begin
					state_nxt.prescAssign = pwdata[0];
				end
			end else if (psel && !penable) begin
				state_nxt.apbReady = 1'b1;
				state_nxt.apbErr   = 1'b0;
				state_nxt.apbData  = alu_exec_pkg::RST_RDATA;
				unique case (paddr)
					// Control
					alu_exec_pkg::REG_CTRL: begin
						state_nxt.apbData[0] = state_r.prescAssign;
					end
					// Accumulator
					alu_exec_pkg::REG_ACCUM: begin
						state_nxt.apbData[7:0] = state_r.accum;
					end
					// Flag byte
					alu_exec_pkg::REG_FLAGS: begin
						state_nxt.apbData[7:0] = state_r.fileReg[alu_exec_pkg::FILE_STATUS];
					end
					// Program counter
					alu_exec_pkg::REG_PC: begin
						state_nxt.apbData[8:0] = state_r.pc;
					end
					// Direction latches
					alu_exec_pkg::REG_DIR: begin
						state_nxt.apbData[23:0] = state_r.dirLatch;
					end
					// Unmapped, also refuses writes
					default: begin
						state_nxt.apbErr = 1'b1;
					end
				endcase
			end
		end
		// Synchronous reset overrides everything, including the clock enable
		if (rst) begin
			state_nxt             = '0;
			state_nxt.accum       = alu_exec_pkg::RST_ACCUM;
			state_nxt.pc          = alu_exec_pkg::RST_PC;
			state_nxt.fileReg     = {32{alu_exec_pkg::RST_FILE}};
			// Pins float until software loads a direction
			state_nxt.dirLatch    = {3{alu_exec_pkg::RST_DIR}};
			state_nxt.outEnable   = ~{3{alu_exec_pkg::RST_DIR}};
			state_nxt.prescAssign = alu_exec_pkg::RST_CTRL;
			state_nxt.apbData     = alu_exec_pkg::RST_RDATA;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		state_r <= state_nxt;
	end

	// Outputs taken straight from flip-flops
	assign pinOut         = state_r.fileReg[7:5];
	assign pinOe          = state_r.outEnable; // RULE4
	assign prescalerClear = state_r.prescClr;
	assign pcValue        = state_r.pc;
	assign prdata         = state_r.apbData;
	assign pready         = state_r.apbReady;
	assign pslverr        = state_r.apbErr;

endmodule

// ### shared/alu_exec_pkg.sv
// Constants, types and register map shared by the execute unit and its arithmetic core
package alu_exec_pkg;

	// File register addresses used by the side effects
	localparam logic [4:0] FILE_TIMER   = 5'h01;   // timer_zero_count
	localparam logic [4:0] FILE_PCL     = 5'h02;   // Low byte of the program counter
	localparam logic [4:0] FILE_STATUS  = 5'h03;   // Flag byte
	localparam logic [4:0] FILE_PORT_A  = 5'h05;   // port_a_a
	localparam logic [4:0] FILE_PORT_C  = 5'h07;   // port_c_c

	// Flag bit positions inside the flag byte
	localparam int FLAG_C  = 0;                    // Carry
	localparam int FLAG_DIGIT = 1;                 // digit_carry_flag
	localparam int FLAG_Z  = 2;                    // Zero

	// Opcode fields
	localparam logic [5:0] OPC_ADD_FILE  = 6'h07;  // add_accum_file, bits 11:6
	localparam logic [5:0] OPC_AND_FILE  = 6'h05;  // and_accum_file, bits 11:6
	localparam logic [3:0] OPC_AND_LIT   = 4'he;   // and_literal_accum, bits 11:8
	localparam logic [8:0] OPC_DIR_LOAD  = 9'h000; // port_direction_load, bits 11:3

	// Register map on the bus, byte addresses
	localparam logic [7:0] REG_CTRL  = 8'h00;      // Bit 0: prescaler assigned to timer
	localparam logic [7:0] REG_ACCUM = 8'h04;      // Accumulator, read only
	localparam logic [7:0] REG_FLAGS = 8'h08;      // Flag byte, read only
	localparam logic [7:0] REG_PC    = 8'h0c;      // Program counter, read only
	localparam logic [7:0] REG_DIR   = 8'h10;      // Direction latches C:B:A, read only

	// Values after reset
	localparam logic [7:0]  RST_ACCUM = 8'h00;
	localparam logic [8:0]  RST_PC    = 9'h000;
	localparam logic [7:0]  RST_DIR   = 8'hff;     // All pins start undriven
	localparam logic [7:0]  RST_FILE  = 8'h00;
	localparam logic        RST_CTRL  = 1'b0;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// Arithmetic operations, one-hot
	typedef enum logic [1:0] {
		ALU_ADD = 2'b01,
		ALU_AND = 2'b10
	} aluOp_t;

endpackage

// ### shared/alu_if.sv
// Operand and result bundle between the execute unit and its arithmetic core
`timescale 1ns/100ps
interface alu_if;
	alu_exec_pkg::aluOp_t op;       // Selected operation
	logic [7:0]           opA;      // Accumulator operand
	logic [7:0]           opB;      // File or literal operand
	logic [7:0]           result;   // Operation result
	logic                 carryOut; // Carry out of bit 7
	logic                 digitOut; // Carry out of bit 3
	logic                 zeroOut;  // Result is zero

	modport core (input op, input opA, input opB, output result, output carryOut,
		output digitOut, output zeroOut);
	modport user (output op, output opA, output opB, input result, input carryOut,
		input digitOut, input zeroOut);
endinterface

// ### hw/alu_core.sv
// Combinational adder and AND unit with flag outputs
`timescale 1ns/100ps
module alu_core (
	alu_if.core alu
);
	logic [8:0] fullSum;    // Sum with carry out
	logic [4:0] nibbleSum;  // Low nibble sum with digit carry

	// Both flavours are computed; the op picks the result and whether the carries are driven
	always_comb begin
		fullSum      = {1'b0, alu.opA} + {1'b0, alu.opB};
		nibbleSum    = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]};
		alu.result   = alu.opA & alu.opB;
		alu.carryOut = 1'b0;
		alu.digitOut = 1'b0;
		unique case (alu.op)
			// Sum with carry and digit carry
			alu_exec_pkg::ALU_ADD: begin
				alu.result   = fullSum[7:0];
				alu.carryOut = fullSum[8];
				alu.digitOut = nibbleSum[4];
			end
			// Bitwise AND, no carries
			alu_exec_pkg::ALU_AND: begin
				alu.result = alu.opA & alu.opB;
			end
			// Unused codes keep the AND defaults set above
			default: begin
			end
		endcase
		alu.zeroOut = (alu.result == 8'h00);
	end

endmodule

// ### verif/alu_exec_props.sv
// Port checker for the execute unit
`timescale 1ns/100ps
module alu_exec_props (
	input wire logic            clock,
	input wire logic            rst,
	input wire logic            ce,
	input wire logic [11:0]     instr,
	input wire logic            instrValid,
	input wire logic [2:0][7:0] pinOe,
	input wire logic            prescalerClear,
	input wire logic [8:0]      pcValue,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pready
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic go;    // Instruction taken at this edge
	logic pcWr;  // Add or AND with the counter low byte as destination
	logic tmrWr; // Any taken instruction whose low six bits are 6'h21; the opcode is not checked
	assign go = ce && instrValid;
	assign pcWr = instr[11:8] == 4'h1 && instr[6] && instr[5:0] == 6'h22;
	assign tmrWr = go && instr[5:0] == 6'h21;
	AST_PC_BIT8: assert property (go && pcWr |=> !pcValue[8])
		else $error("counter bit eight set after low byte write");
	AST_PC_STEP: assert property (go && !pcWr |=> pcValue == $past(pcValue) + 9'h1)
		else $error("counter did not advance by one");
	AST_PRESC_CAUSE: assert property (prescalerClear && $past(ce) |-> $past(tmrWr))
		else $error("prescaler clear without timer write");
	AST_PRESC_IDLE: assert property (ce && !instrValid |=> !prescalerClear)
		else $error("prescaler clear with no instruction");
	AST_OE_HOLD: assert property (!(go && instr[11:3] == 9'h000) |=> $stable(pinOe))
		else $error("driver enables moved without direction load");
	AST_OE_ONE: assert property (go && instr == 12'h005 |=> $stable(pinOe[2:1]))
		else $error("port A load touched other ports");
	AST_RDY: assert property (ce && psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_RDY_ONE: assert property (ce && pready |=> !pready)
		else $error("ready held too long");
	AST_FREEZE: assert property (!ce |=> $stable(pcValue))
		else $error("counter moved while disabled");
endmodule

// ### verif/prog_mem.sv
// Program memory model feeding instruction words by counter value
`timescale 1ns/100ps
module prog_mem (
	input wire logic [8:0] pcValue,
	output logic     [11:0] instr
);
	logic [11:0] mem [512]; // Zero fill reads as an ignored direction load
	initial
		foreach (mem[i]) mem[i] = 12'h000;
	assign instr = mem[pcValue];
endmodule

// ### verif/tb.sv
// Self-checking bench for the execute unit
`timescale 1ns/100ps
module tb;
	logic            clock, rst, ce, instrValid, psel, penable, pwrite, pready, pslverr;
	logic            prescalerClear, errVal;
	logic [7:0]      paddr;
	logic [11:0]     instr;
	logic [31:0]     pwdata, prdata, rdVal;
	logic [2:0][7:0] pinIn, pinOut, pinOe;
	logic [8:0]      pcValue, pcKeep;
	int              fail_count, total_checks;

	alu_instruction_execute u_alu_instruction_execute (
		.clock          (clock),
		.rst            (rst),
		.ce             (ce),
		.instr          (instr),
		.instrValid     (instrValid),
		.pinIn          (pinIn),
		.pinOut         (pinOut),
		.pinOe          (pinOe),
		.prescalerClear (prescalerClear),
		.pcValue        (pcValue),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr)
	);
	prog_mem u_prog_mem (
		.pcValue (pcValue),
		.instr   (instr)
	);

	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected %s exp %h got %h", what, exp, got);
			fail_count++;
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One bus transfer; waits a bounded time for ready
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!pready && n < 8);
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			fail_count++;
			conclude();
		end
		@(negedge clock);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
		apb(1'h0, a, 32'h0000_0000);
		chk(what, exp, rdVal);
	endtask

	// Word placed at the counter, taken on one enabled edge
	task automatic exe(logic [11:0] w);
		u_prog_mem.mem[pcValue] = w;
		@(posedge clock);
		instrValid <= 1'h1;
		@(posedge clock);
		instrValid <= 1'h0;
		@(negedge clock);
	endtask

	// Pin change needs a few edges through the synchroniser
	task automatic setPin(logic [7:0] v);
		@(posedge clock);
		pinIn[0] <= v;
		repeat (5) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic t_arith();
		setPin(8'ha3);
		exe(12'h1c5);
		exe(12'he5f);
		rd(8'h04, 32'h0000_0003, "accum literal");
		setPin(8'hfe);
		exe(12'h1e5);
		chk("port A sum", 32'h0000_0001, pinOut[0]);
		rd(8'h08, 32'h0000_0003, "flags add");
		rd(8'h04, 32'h0000_0003, "accum kept");
		exe(12'h145);
		rd(8'h04, 32'h0000_0002, "accum from pins");
		setPin(8'hfd);
		exe(12'h165);
		chk("port A and", 32'h0000_0000, pinOut[0]);
		rd(8'h08, 32'h0000_0007, "flags and");
		$display("arith test done");
	endtask

	task automatic t_dir();
		for (int f = 5; f < 8; f++) begin
			exe(12'(f));
			chk("driver enable", 32'h0000_00fd, pinOe[f-5]);
		end
		exe(12'h004);
		chk("all enables", 32'h00fd_fdfd, pinOe);
		rd(8'h10, 32'h0002_0202, "direction");
		$display("direction test done");
	endtask

	task automatic t_presc();
		apb(1'h1, 8'h00, 32'h0000_0001);
		rd(8'h00, 32'h0000_0001, "ctrl");
		exe(12'h1e1);
		chk("clear d1", 32'h0000_0001, prescalerClear);
		exe(12'h1c1);
		chk("clear d0", 32'h0000_0000, prescalerClear);
		apb(1'h1, 8'h00, 32'h0000_0000);
		exe(12'h1e1);
		chk("clear unassigned", 32'h0000_0000, prescalerClear);
		$display("prescaler test done");
	endtask

	task automatic t_bus();
		apb(1'h1, 8'h04, 32'h0000_00ff);
		chk("ro write err", 32'h0000_0000, errVal);
		rd(8'h04, 32'h0000_0004, "accum after ro write");
		rd(8'h20, 32'h0000_0000, "unmapped data");
		chk("unmapped err", 32'h0000_0001, errVal);
		$display("bus test done");
	endtask

	// Run the counter past 255, freeze it, then write its low byte
	task automatic t_pc();
		@(posedge clock);
		instrValid <= 1'h1;
		repeat (260) @(posedge clock);
		instrValid <= 1'h0;
		@(negedge clock);
		chk("counter high", 32'h0000_0001, pcValue[8]);
		pcKeep = pcValue;
		@(posedge clock);
		ce <= 1'h0;
		instrValid <= 1'h1;
		repeat (3) @(posedge clock);
		ce <= 1'h1;
		instrValid <= 1'h0;
		@(negedge clock);
		chk("counter frozen", pcKeep, pcValue);
		rd(8'h0c, 32'h0000_0110, "counter reg");
		exe(12'h162);
		chk("counter bit eight", 32'h0000_0000, pcValue[8]);
		$display("counter test done");
	endtask

	initial begin
		rst = 1'h1;
		ce = 1'h1;
		instrValid = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pinIn = '0;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		@(negedge clock);
		t_arith();
		t_dir();
		t_presc();
		t_bus();
		t_pc();
		conclude();
	end
endmodule

bind alu_instruction_execute alu_exec_props u_alu_exec_props (
	.clock          (clock),
	.rst            (rst),
	.ce             (ce),
	.instr          (instr),
	.instrValid     (instrValid),
	.pinOe          (pinOe),
	.prescalerClear (prescalerClear),
	.pcValue        (pcValue),
	.psel           (psel),
	.penable        (penable),
	.pready         (pready)
);
